// *** core/dtsb_pkg.sv ***
// Package for the display timing status and blink block
package dtsb_pkg;
   // Register byte addresses
   localparam logic [15:0] TIMING_CFG_ADDR = 16'h8308;
   localparam logic [15:0] GENERAL_CFG_ADDR = 16'h8304;
   // General configuration fields
   localparam int GEN_FIFO_FETCH_BIT = 0;
   localparam int GEN_CURSOR_BIT = 1;
   localparam logic [31:0] GEN_RESET = 32'h00000000;
   localparam logic [31:0] GEN_WMASK = 32'h00000003;
   // Timing configuration fields
   localparam int TIM_VIRQ_BIT = 31;
   localparam int TIM_VINACT_BIT = 30;
   localparam int TIM_LINACT_BIT = 29;
   localparam int TIM_MONID_BIT = 27;
   localparam int TIM_BLINK_BIT = 16;
   localparam logic [31:0] TIM_RESET = 32'h00000000;
   localparam logic [31:0] TIM_WMASK = 32'h0000FFFF | 32'h00010000;
   // Blink frame counter width
   localparam int FRAME_W = 6;

   // Raster status from the timing generator
   typedef struct packed {
      logic vsync;
      logic vactive;
      logic hactive;
   } dtsb_raster_t;

   // Blink outputs
   typedef struct packed {
      logic cursor_vis;
      logic text_vis;
   } dtsb_blink_t;
endpackage : dtsb_pkg

// *** core/dtsb_blink.sv ***
// Blink phase generator driven by a frame counter
`timescale 1ns/1ps
`default_nettype none
module dtsb_blink (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic frame_tick,
   input wire logic slow,
   // Result
   output dtsb_pkg::dtsb_blink_t blink
);
   typedef struct packed {
      logic [dtsb_pkg::FRAME_W-1:0] frame;
   } dtsb_bstate_t;
   dtsb_bstate_t st_reg;
   dtsb_bstate_t st_next;

   always_comb begin
      st_next = st_reg;
      if (frame_tick) begin
         st_next.frame = st_reg.frame + 6'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Both rates: visible in first half
   always_comb begin
      if (slow) begin
         blink.cursor_vis = ~st_reg.frame[4];
         blink.text_vis = ~st_reg.frame[5];
      end else begin
         blink.cursor_vis = ~st_reg.frame[3];
         blink.text_vis = ~st_reg.frame[4];
      end
   end

   a_frame_step: assert property (@(posedge pclk) disable iff (!presetn)
      frame_tick |=> st_reg.frame == $past(st_reg.frame) + 6'h01)
      else $error("frame counter did not step");
   // Cursor shown for 8 of 16 frames
   a_fast_cursor: assert property (@(posedge pclk) disable iff (!presetn)
      !slow |-> blink.cursor_vis == (st_reg.frame[3:0] < 4'h8))
      else $error("fast cursor blink wrong");
   // Text shown for 32 of 64 frames
   a_slow_text: assert property (@(posedge pclk) disable iff (!presetn)
      slow |-> blink.text_vis == (st_reg.frame < 6'h20))
      else $error("slow text blink wrong");
endmodule : dtsb_blink
`default_nettype wire

// *** core/dtsb_top.sv ***
// Display timing status, FIFO fetch gating and blink control
// What this block does
// - Cursor bit enables the hardware cursor
// - Fetch into FIFO only when enabled
// - No FIFO writes or reads when disabled
// - Bit 31 reads pending vertical interrupt
// - Bit 30 high outside active frame
// - Bit 29 high outside active line
// - Bit 27 returns monitor id pin
// - Normal blink: cursor 16/8, text 32/16
// - Slow blink: cursor 32/16, text 64/32
// - Timing register writable only when unlocked
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module dtsb_top (
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Lock and raster status from the controller core
   input wire logic unlocked,
   input wire dtsb_pkg::dtsb_raster_t raster,
   input wire logic vertical_irq_pending,
   // Monitor id pin, asynchronous
   input wire logic monitor_id_input_pin,
   // FIFO requests from fetch logic and pixel pipe
   input wire logic fifo_wr_req,
   input wire logic fifo_rd_req,
   // Controls out
   output logic fifo_wr_en,
   output logic fifo_rd_en,
   output logic hw_cursor_on,
   output logic cursor_visible,
   output logic text_visible
);
   typedef struct packed {
      logic [31:0] gen;
      logic [31:0] tim;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic [1:0] id_sync;
      logic vsync_d;
      logic wr_en;
      logic rd_en;
      logic cursor_on;
      logic cursor_vis;
      logic text_vis;
   } dtsb_state_t;

   dtsb_state_t st_reg;
   dtsb_state_t st_next;
   dtsb_pkg::dtsb_blink_t blink;
   logic frame_tick;
   logic access;
   logic [31:0] status_word;

   ////////////////////////////////////////////////////////////////////
   // Blink generator
   // One vsync rising edge per frame
   assign frame_tick = raster.vsync & ~st_reg.vsync_d;

   dtsb_blink u_blink (
      .pclk(pclk),
      .presetn(presetn),
      .frame_tick(frame_tick),
      .slow(st_reg.tim[dtsb_pkg::TIM_BLINK_BIT]),
      .blink(blink)
   );

   ////////////////////////////////////////////////////////////////////
   // Status view of the timing register
   // Access is taken in the first access cycle and answered in the next
   assign access = psel & penable & ~st_reg.ready;

   // Live status bits over stored fields
   always_comb begin
      status_word = st_reg.tim;
      status_word[dtsb_pkg::TIM_VIRQ_BIT] = vertical_irq_pending;
      status_word[dtsb_pkg::TIM_VINACT_BIT] = ~raster.vactive;
      status_word[dtsb_pkg::TIM_LINACT_BIT] = ~raster.hactive;
      status_word[dtsb_pkg::TIM_MONID_BIT] = st_reg.id_sync[1];
   end

   ////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_next = st_reg;
      st_next.ready = access;
      st_next.slverr = 1'b0;
      st_next.rdata = 32'h00000000;
      // Two-stage sync; only stage one feeds stage two
      st_next.id_sync = {st_reg.id_sync[0], monitor_id_input_pin};
      st_next.vsync_d = raster.vsync;
      if (access) begin
         case (paddr)
            dtsb_pkg::GENERAL_CFG_ADDR: begin
               if (pwrite) begin
                  st_next.gen = pwdata & dtsb_pkg::GEN_WMASK;
               end else begin
                  st_next.rdata = st_reg.gen;
               end
            end
            dtsb_pkg::TIMING_CFG_ADDR: begin
               if (pwrite) begin
                  // Locked writes are refused with an error
                  if (unlocked) begin
                     st_next.tim = pwdata & dtsb_pkg::TIM_WMASK;
                  end else begin
                     st_next.slverr = 1'b1;
                  end
               end else begin
                  st_next.rdata = status_word;
               end
            end
            default: begin
               st_next.slverr = 1'b1;
            end
         endcase
      end
      // FIFO traffic gated by fetch enable
      st_next.wr_en = fifo_wr_req & st_reg.gen[dtsb_pkg::GEN_FIFO_FETCH_BIT];
      st_next.rd_en = fifo_rd_req & st_reg.gen[dtsb_pkg::GEN_FIFO_FETCH_BIT];
      st_next.cursor_on = st_reg.gen[dtsb_pkg::GEN_CURSOR_BIT];
      st_next.cursor_vis = blink.cursor_vis & st_reg.gen[dtsb_pkg::GEN_CURSOR_BIT];
      st_next.text_vis = blink.text_vis;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
         st_reg.gen <= dtsb_pkg::GEN_RESET;
         st_reg.tim <= dtsb_pkg::TIM_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs straight from flops
   assign prdata = st_reg.rdata;
   assign pready = st_reg.ready;
   assign pslverr = st_reg.slverr;
   assign fifo_wr_en = st_reg.wr_en;
   assign fifo_rd_en = st_reg.rd_en;
   assign hw_cursor_on = st_reg.cursor_on;
   assign cursor_visible = st_reg.cursor_vis;
   assign text_visible = st_reg.text_vis;

   ////////////////////////////////////////////////////////////////////
   // Checks
   // No FIFO activity while disabled
   a_fifo_gated: assert property (@(posedge pclk) disable iff (!presetn)
      (fifo_wr_en | fifo_rd_en) |-> $past(st_reg.gen[0]))
      else $error("fifo active while fetch disabled");
   a_fifo_pass: assert property (@(posedge pclk) disable iff (!presetn)
      (fifo_wr_req & st_reg.gen[0]) |=> fifo_wr_en)
      else $error("fetch request dropped");
   a_cursor_en: assert property (@(posedge pclk) disable iff (!presetn)
      !st_reg.gen[1] |=> !hw_cursor_on && !cursor_visible)
      else $error("cursor shown while disabled");
   a_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (access & pwrite & ~unlocked & paddr == 16'h8308) |=> $stable(st_reg.tim) && pslverr)
      else $error("locked write took effect");
   a_vflag_read: assert property (@(posedge pclk) disable iff (!presetn)
      (access & ~pwrite & paddr == 16'h8308) |=> prdata[30] == $past(~raster.vactive))
      else $error("vertical flag wrong");
   a_hflag_read: assert property (@(posedge pclk) disable iff (!presetn)
      (access & ~pwrite & paddr == 16'h8308) |=> prdata[29] == $past(~raster.hactive))
      else $error("line flag wrong");
   a_virq_read: assert property (@(posedge pclk) disable iff (!presetn)
      (access & ~pwrite & paddr == 16'h8308) |=> prdata[31] == $past(vertical_irq_pending))
      else $error("irq bit wrong");
   a_monid_read: assert property (@(posedge pclk) disable iff (!presetn)
      (access & ~pwrite & paddr == 16'h8308) |=> prdata[27] == $past(monitor_id_input_pin, 3))
      else $error("monitor id bit wrong");

   ////////////////////////////////////////////////////////////////////
   // Bus handshake checks
   // The slave always inserts exactly one wait state, so the master
   // never sees a late answer; a stuck answer would hang software.
   // Answer follows a taken request
   a_ready_next: assert property (@(posedge pclk) disable iff (!presetn)
      access |=> pready)
      else $error("no answer after access");
   // Ready is a one-cycle pulse
   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready held too long");
   // Ready only after a taken request
   a_ready_cause: assert property (@(posedge pclk) disable iff (!presetn)
      !access |=> !pready)
      else $error("ready without request");
   // A request is taken once only
   a_access_once: assert property (@(posedge pclk) disable iff (!presetn)
      access |=> !access)
      else $error("request taken twice");
   // Error only with ready
   a_err_with_rdy: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error without ready");
   // Read data is zero outside the answer
   a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == 32'h00000000)
      else $error("read data outside answer");
   // Unmapped address refused with zero data
   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      (access & paddr != 16'h8304 & paddr != 16'h8308) |=>
         pslverr && prdata == 32'h00000000)
      else $error("unmapped access not refused");

   ////////////////////////////////////////////////////////////////////
   // Register content checks
   // Unlocked timing write lands
   a_tim_write: assert property (@(posedge pclk) disable iff (!presetn)
      (access & pwrite & unlocked & paddr == 16'h8308) |=>
         st_reg.tim == ($past(pwdata) & 32'h0001FFFF) && !pslverr)
      else $error("timing write lost");
   // Timing register changes only on writes
   a_tim_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(access & pwrite & paddr == 16'h8308) |=> $stable(st_reg.tim))
      else $error("timing register changed alone");
   a_tim_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
      (access & ~pwrite & paddr == 16'h8308) |=>
         prdata[28] == 1'b0 && prdata[26:17] == 10'h000)
      else $error("reserved timing bits set");
   a_status_ok: assert property (@(posedge pclk) disable iff (!presetn)
      (access & ~pwrite & paddr == 16'h8308) |=> !pslverr)
      else $error("status read refused");
   a_gen_write: assert property (@(posedge pclk) disable iff (!presetn)
      (access & pwrite & paddr == 16'h8304) |=>
         st_reg.gen == ($past(pwdata) & 32'h00000003) && !pslverr)
      else $error("general write lost");
   // General register changes only on writes
   a_gen_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(access & pwrite & paddr == 16'h8304) |=> $stable(st_reg.gen))
      else $error("general register changed alone");
   // General reads show two bits only
   a_gen_read: assert property (@(posedge pclk) disable iff (!presetn)
      (access & ~pwrite & paddr == 16'h8304) |=> prdata[31:2] == 30'h00000000)
      else $error("general read upper bits set");

   ////////////////////////////////////////////////////////////////////
   // FIFO gating and display controls
   // Enabled fetch passes read requests
   a_rd_pass: assert property (@(posedge pclk) disable iff (!presetn)
      (fifo_rd_req & st_reg.gen[0]) |=> fifo_rd_en)
      else $error("read request dropped");
   a_fetch_off: assert property (@(posedge pclk) disable iff (!presetn)
      !st_reg.gen[0] |=> !fifo_wr_en && !fifo_rd_en)
      else $error("fifo traffic while disabled");
   a_cursor_set: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.gen[1] |=> hw_cursor_on)
      else $error("cursor enable lost");
   a_cursor_blink: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.gen[1] |=> cursor_visible == $past(blink.cursor_vis))
      else $error("cursor blink not passed");
   a_text_follow: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> text_visible == $past(blink.text_vis))
      else $error("text blink not passed");
   a_tick_single: assert property (@(posedge pclk) disable iff (!presetn)
      frame_tick |=> !frame_tick)
      else $error("frame tick repeated");
   a_vsync_delay: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> st_reg.vsync_d == $past(raster.vsync))
      else $error("vsync delay wrong");
   // First sync stage samples the pin
   a_id_stage1: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> st_reg.id_sync[0] == $past(monitor_id_input_pin))
      else $error("id first stage wrong");
   a_id_stage2: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 ##1 1'b1 |=> st_reg.id_sync[1] == $past(monitor_id_input_pin, 2))
      else $error("id second stage wrong");
endmodule : dtsb_top
`default_nettype wire

// *** test/dtsb_monitor.sv ***
// Display monitor model: raster timing and id line
`timescale 1ns/1ps
`default_nettype none
module dtsb_monitor (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench control
   input wire logic run,
   input wire logic id_level,
   // To the block
   output var dtsb_pkg::dtsb_raster_t raster,
   output logic monitor_id_input_pin
);
   logic [5:0] pos;
   // Eight lines of eight clocks; freezing lets the bench read a known raster spot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pos <= 6'h00;
      else if (run) pos <= pos + 6'h01;
   end
   // Six active clocks and lines, sync in the last line
   assign raster.hactive = pos[2:0] < 3'h6;
   assign raster.vactive = pos[5:3] < 3'h6;
   assign raster.vsync = pos[5:3] == 3'h7;
   assign monitor_id_input_pin = id_level;
endmodule : dtsb_monitor
`default_nettype wire

// *** test/tb_dtsb_top.sv ***
// Self-checking bench for the display timing status and blink block
`timescale 1ns/1ps
`default_nettype none
module tb_dtsb_top;
   localparam logic [15:0] GEN = dtsb_pkg::GENERAL_CFG_ADDR;
   localparam logic [15:0] TIM = dtsb_pkg::TIMING_CFG_ADDR;
   logic pclk, presetn, psel, penable, pwrite, unlocked, virq, id_lvl, run, wreq, rreq;
   logic pready, pslverr, err, fwe, fre, curs_on, curs_vis, txt_vis, id_pin;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   dtsb_pkg::dtsb_raster_t raster;
   int mismatches = 0;
   int tests_run = 0;
   dtsb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .unlocked(unlocked), .raster(raster), .vertical_irq_pending(virq),
      .monitor_id_input_pin(id_pin), .fifo_wr_req(wreq), .fifo_rd_req(rreq),
      .fifo_wr_en(fwe), .fifo_rd_en(fre), .hw_cursor_on(curs_on),
      .cursor_visible(curs_vis), .text_visible(txt_vis));
   dtsb_monitor mon (.pclk(pclk), .presetn(presetn), .run(run), .id_level(id_lvl),
      .raster(raster), .monitor_id_input_pin(id_pin));
   // Clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   // One APB transfer; an idle edge after it keeps psel from two writes in one step
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      if (n >= 50) chk("pready", 32'h0, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      apb(1'b0, GEN, 32'h0);
      chk("general reset", rd, dtsb_pkg::GEN_RESET); // fetch off
      apb(1'b1, GEN, 32'hFFFFFFFF);
      apb(1'b0, GEN, 32'h0);
      chk("general bits", rd, 32'h00000003); // cursor bit
      chk("cursor on", {31'h0, curs_on}, 32'h1); // cursor bit
      apb(1'b0, 16'h0010, 32'h0);
      chk("unmapped err", {31'h0, err}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      $display("test regs done");
   endtask : t_regs
   task automatic t_lock();
      unlocked <= 1'b0;
      apb(1'b1, TIM, 32'h0001ABCD);
      chk("locked err", {31'h0, err}, 32'h1); // locked write
      unlocked <= 1'b1;
      apb(1'b0, TIM, 32'h0);
      chk("locked keep", rd & 32'h0001FFFF, 32'h0); // locked write
      apb(1'b1, TIM, 32'h0001ABCD);
      apb(1'b0, TIM, 32'h0);
      chk("timing rw", rd & 32'h0001FFFF, 32'h0001ABCD); // slow select
      $display("test lock done");
   endtask : t_lock
   // Freeze the raster at several spots and read the status bits
   task automatic t_status();
      for (int i = 0; i < 4; i++) begin
         run <= 1'b0;
         virq <= i[0];
         id_lvl <= ~i[0];
         repeat (5) @(posedge pclk);
         apb(1'b0, TIM, 32'h0);
         chk("status", rd & 32'hFFFF0000, {virq, ~raster.vactive, ~raster.hactive,
            1'b0, id_lvl, 11'h001, 16'h0}); // status bits
         run <= 1'b1;
         repeat (13 + i * 11) @(posedge pclk);
      end
      $display("test status done");
   endtask : t_status
   // fetch on first: cursor is cleared in the same write that keeps fetch on
   task automatic t_fifo();
      for (int i = 1; i >= 0; i--) begin
         apb(1'b1, GEN, {31'h0, i[0]});
         wreq <= 1'b1;
         rreq <= 1'b1;
         repeat (2) @(posedge pclk);
         chk("fifo wr", {31'h0, fwe}, {31'h0, i[0]}); // fetch gating
         chk("fifo rd", {31'h0, fre}, {31'h0, i[0]}); // read gating
         wreq <= 1'b0;
         rreq <= 1'b0;
      end
      $display("test fifo done");
   endtask : t_fifo
   // One sample per 64-clock frame over 128 frames, both rates
   task automatic t_blink();
      int cv, tv, cr, tr, al;
      logic pc, pt;
      apb(1'b1, GEN, 32'h3);
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, TIM, {15'h0, s[0], 16'h0});
         repeat (200) @(posedge pclk);
         {cv, tv, cr, tr, al} = '0;
         {pc, pt} = {curs_vis, txt_vis};
         for (int f = 0; f < 128; f++) begin
            repeat (64) @(posedge pclk);
            cv += curs_vis;
            tv += txt_vis;
            cr += curs_vis & ~pc;
            tr += txt_vis & ~pt;
            al += txt_vis & ~pt & ~(curs_vis & ~pc);
            {pc, pt} = {curs_vis, txt_vis};
         end
         chk("cursor vis", cv, 64); // cursor duty
         chk("cursor rise", cr, 128 / (16 << s)); // cursor period
         chk("text vis", tv, 64); // text duty
         chk("text rise", tr, 128 / (32 << s)); // text period
         chk("phase", al, 0); // shared counter
      end
      $display("test blink done");
   endtask : t_blink
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, virq, id_lvl, wreq, rreq} = '0;
      {unlocked, run} = 2'h3;
      paddr = 16'h0;
      pwdata = 32'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_lock();
      t_status();
      t_fifo();
      t_blink();
      wrap_up();
   end
   // Watchdog well past the roughly 17000-cycle run
   initial begin
      repeat (40000) @(posedge pclk);
      chk("watchdog", 32'h0, 32'h1);
      wrap_up();
   end
endmodule : tb_dtsb_top
`default_nettype wire
